// >>> tcc_top.sv
// Timer channel 1 compare, shared flags and AXI4-Lite register slave
// What this block does
// - When enabled, apply selected action (bits 5:3) whenever count equals channel 1 byte on a timer tick.
// - On match, code 000 drives output high, 001 low, 010 inverts it.
// - 011 sets on up-compare, clears at zero or down-compare; 100 is inverse.
// - 101 sets on match, clears at channel 0 value; 110 is inverse.
// - Control bit 2 enables channel 1 compare; resets to 0.
// - Eight-bit read/write channel 1 compare byte, reset to zero.
// - Flag register bit 6 masks the wide timer overflow interrupt; resets to 1.
// - Second timer pending flags: channel 1 bit 5, channel 0 bit 4, overflow bit 3.
// - First timer pending flags: channel 1 bit 2, channel 0 bit 1, overflow bit 0.
// - Writing 1 leaves a pending flag alone; writing 0 clears it.
// - Up/down mode counts zero to channel 0 value and back; down-compares arise there.
`timescale 1ns/1ps
module tcc_top #(
	parameter int ADDR_W = tcc_pkg::ADDR_W
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [7:0]        timer_count,
	input  wire logic              timer_tick,
	input  wire logic [7:0]        ch0_compare_byte,
	input  wire logic              count_down,
	input  wire logic              updown_mode,
	input  wire logic              first_timer_ch0_evt,
	input  wire logic              first_timer_ch1_evt,
	input  wire logic              first_timer_ovf_evt,
	input  wire logic              second_timer_ch0_evt,
	input  wire logic              second_timer_ovf_evt,
	input  wire logic              wide_ovf_pending,
	output logic                   ch1_out,
	output logic                   ch1_irq_req,
	output logic                   wide_ovf_irq_req,
	output logic                   irq
);
	tcc_cmp_if cmp_link ();

	logic [7:0]        ch1_compare_control_reg;
	logic [7:0]        ch1_compare_byte_reg;
	logic [7:0]        shared_timer_flag_reg;
	logic [7:0]        flag_set;
	logic [7:0]        flag_clr;
	logic [1:0]        stat_reg;
	logic [1:0]        stat_set;
	logic [1:0]        stat_clr;
	logic [1:0]        mask_reg;
	logic              aw_hold_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic              w_hold_reg;
	logic [7:0]        w_data_reg;
	logic              w_lane_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;
	logic              ch1_irq_reg;
	logic              wide_irq_reg;
	logic              irq_reg;
	logic              commit;
	logic              do_wr;
	logic              rd_take;
	logic [2:0]        wr_sel;
	logic [2:0]        rd_sel;

	// Register decode: 1 flags, 2 control, 3 value, 4 status, 5 mask, 0 unmapped
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			tcc_pkg::ADDR_FLAGS: reg_sel = 3'h1;
			tcc_pkg::ADDR_CTRL:  reg_sel = 3'h2;
			tcc_pkg::ADDR_VALUE: reg_sel = 3'h3;
			tcc_pkg::ADDR_STAT:  reg_sel = 3'h4;
			tcc_pkg::ADDR_MASK:  reg_sel = 3'h5;
			default:             reg_sel = 3'h0;
		endcase
	endfunction

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign ch1_out = cmp_link.pin;
	assign ch1_irq_req = ch1_irq_reg;
	assign wide_ovf_irq_req = wide_irq_reg;
	assign irq = irq_reg;

	assign commit = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_sel = reg_sel(aw_addr_reg);
	// Only the low byte lane holds register bits
	assign do_wr = commit && w_lane_reg;
	assign rd_take = s_axi_arvalid && arready_reg;
	assign rd_sel = reg_sel(s_axi_araddr);

	// Write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			awready_reg <= 1'b0;
		end else if (s_axi_awvalid && awready_reg) begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
			awready_reg <= 1'b0;
		end else if (commit) begin
			aw_hold_reg <= 1'b0;
		end else if (!aw_hold_reg && !bvalid_reg) begin
			awready_reg <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
			wready_reg <= 1'b0;
		end else if (s_axi_wvalid && wready_reg) begin
			w_hold_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_lane_reg <= s_axi_wstrb[0];
			wready_reg <= 1'b0;
		end else if (commit) begin
			w_hold_reg <= 1'b0;
		end else if (!w_hold_reg && !bvalid_reg) begin
			wready_reg <= 1'b1;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= tcc_pkg::RESP_OKAY;
		end else if (commit) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wr_sel == 3'h0) ? tcc_pkg::RESP_SLVERR : tcc_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read channel; data sampled at address acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= tcc_pkg::RESP_OKAY;
			rdata_reg <= 32'h0;
		end else if (rd_take) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= (rd_sel == 3'h0) ? tcc_pkg::RESP_SLVERR : tcc_pkg::RESP_OKAY;
			case (rd_sel)
				3'h1: rdata_reg <= {24'h0, 1'b0, shared_timer_flag_reg[6:0]};
				3'h2: rdata_reg <= {24'h0, 1'b0, ch1_compare_control_reg[6:0]};
				3'h3: rdata_reg <= {24'h0, ch1_compare_byte_reg};
				3'h4: rdata_reg <= {30'h0, stat_reg};
				3'h5: rdata_reg <= {30'h0, mask_reg};
				default: rdata_reg <= 32'h0;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end else if (!rvalid_reg) begin
			arready_reg <= 1'b1;
		end
	end

	// channel mask resets enabled, bit 7 reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ch1_compare_control_reg <= tcc_pkg::CTRL_RST;
		else if (do_wr && wr_sel == 3'h2)
			ch1_compare_control_reg <= w_data_reg & tcc_pkg::CTRL_WMASK;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ch1_compare_byte_reg <= tcc_pkg::VALUE_RST;
		else if (do_wr && wr_sel == 3'h3)
			ch1_compare_byte_reg <= w_data_reg;
	end

	always_comb begin
		flag_set = 8'h00;
		flag_set[tcc_pkg::FL_S_CH1] = cmp_link.match;
		flag_set[tcc_pkg::FL_S_CH0] = second_timer_ch0_evt;
		flag_set[tcc_pkg::FL_S_OVF] = second_timer_ovf_evt;
		flag_set[tcc_pkg::FL_F_CH1] = first_timer_ch1_evt;
		flag_set[tcc_pkg::FL_F_CH0] = first_timer_ch0_evt;
		flag_set[tcc_pkg::FL_F_OVF] = first_timer_ovf_evt;
	end

	// zeros written clear flags, ones ignored
	assign flag_clr = (do_wr && wr_sel == 3'h1) ? (~w_data_reg & tcc_pkg::FLAGS_PEND) : 8'h00;

	// events set flags, set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shared_timer_flag_reg <= tcc_pkg::FLAGS_RST;
		end else begin
			shared_timer_flag_reg[5:0] <= (shared_timer_flag_reg[5:0] & ~flag_clr[5:0])
				| flag_set[5:0];
			if (do_wr && wr_sel == 3'h1)
				shared_timer_flag_reg[tcc_pkg::FL_OVFM_BIT] <= w_data_reg[tcc_pkg::FL_OVFM_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch1_irq_reg <= 1'b0;
			wide_irq_reg <= 1'b0;
		end else begin
			ch1_irq_reg <= shared_timer_flag_reg[tcc_pkg::FL_S_CH1]
				&& ch1_compare_control_reg[tcc_pkg::CTRL_IM_BIT];
			wide_irq_reg <= wide_ovf_pending && shared_timer_flag_reg[tcc_pkg::FL_OVFM_BIT];
		end
	end

	// Sticky status cleared by reading it; a same-cycle event survives the read
	assign stat_set = {|flag_set, cmp_link.match};
	assign stat_clr = (rd_take && rd_sel == 3'h4) ? 2'h3 : 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			stat_reg <= tcc_pkg::STAT_RST;
		else
			stat_reg <= (stat_reg & ~stat_clr) | stat_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mask_reg <= tcc_pkg::MASK_RST;
		else if (do_wr && wr_sel == 3'h5)
			mask_reg <= w_data_reg[1:0];
	end

	// Registered, so irq trails the status bit by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(stat_reg & mask_reg);
	end

	// action and enable to the unit
	// direction and mode from the counter
	assign cmp_link.count = timer_count;
	assign cmp_link.ch0 = ch0_compare_byte;
	assign cmp_link.ch1 = ch1_compare_byte_reg;
	assign cmp_link.action = tcc_pkg::tcc_act_t'(
		ch1_compare_control_reg[tcc_pkg::CTRL_ACT_MSB:tcc_pkg::CTRL_ACT_LSB]);
	assign cmp_link.enable = ch1_compare_control_reg[tcc_pkg::CTRL_EN_BIT];
	assign cmp_link.tick = timer_tick;
	assign cmp_link.down = count_down;
	assign cmp_link.updown = updown_mode;

	tcc_cmp_unit u_cmp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.cmp     (cmp_link)
	);

	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_mode_off_hold: assert property (
		!ch1_compare_control_reg[tcc_pkg::CTRL_EN_BIT] |=> $stable(ch1_out))
		else $error("output moved while compare disabled");
	a_value_write: assert property (
		do_wr && wr_sel == 3'h3 |=> ch1_compare_byte_reg == $past(w_data_reg))
		else $error("compare byte not updated by write");
	a_wide_mask: assert property (
		wide_ovf_irq_req == $past(wide_ovf_pending && shared_timer_flag_reg[6]))
		else $error("wide overflow request not gated by mask");
	a_match_flag: assert property (
		cmp_link.match |=> shared_timer_flag_reg[tcc_pkg::FL_S_CH1])
		else $error("channel 1 match did not set pending flag");
	a_first_flags: assert property (
		first_timer_ch0_evt ##0 first_timer_ovf_evt |=> shared_timer_flag_reg[1:0] == 2'h3)
		else $error("first timer flags not set");
	a_one_keeps: assert property (
		shared_timer_flag_reg[5] && do_wr && wr_sel == 3'h1 && w_data_reg[5]
		|=> shared_timer_flag_reg[5])
		else $error("writing one cleared a pending flag");
	a_zero_clears: assert property (
		do_wr && wr_sel == 3'h1 && !w_data_reg[0] && !first_timer_ovf_evt
		|=> !shared_timer_flag_reg[0])
		else $error("writing zero did not clear flag");
	a_ch1_irq_gate: assert property (
		ch1_irq_req |-> $past(ch1_compare_control_reg[6] && shared_timer_flag_reg[5]))
		else $error("channel 1 request raised while masked");
	a_bresp_wait: assert property (
		commit |=> s_axi_bvalid [*1] ##0 (!s_axi_awready && !s_axi_wready))
		else $error("write response not raised after commit");
	c_write: cover property (commit && wr_sel == 3'h2);
	c_read_stat: cover property (rd_take && rd_sel == 3'h4 && stat_reg != 2'h0);
	c_irq: cover property (irq ##1 !irq);
endmodule

// >>> tcc_pkg.sv
// Constants shared by the timer channel 1 compare block
package tcc_pkg;
	localparam int ADDR_W = 12;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [9:0] IDX_FLAGS = 10'h0D8;
	localparam logic [9:0] IDX_CTRL  = 10'h0EE;
	localparam logic [9:0] IDX_VALUE = 10'h0EF;
	localparam logic [9:0] IDX_STAT  = 10'h100;
	localparam logic [9:0] IDX_MASK  = 10'h101;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_VALUE = {IDX_VALUE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STAT  = {IDX_STAT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MASK  = {IDX_MASK, 2'h0};
	// Control register fields
	localparam int CTRL_IM_BIT  = 6;
	localparam int CTRL_ACT_MSB = 5;
	localparam int CTRL_ACT_LSB = 3;
	localparam int CTRL_EN_BIT  = 2;
	localparam logic [7:0] CTRL_RST    = 8'h40;
	localparam logic [7:0] CTRL_WMASK  = 8'h7F;
	localparam logic [7:0] VALUE_RST   = 8'h00;
	// Shared flag register fields
	localparam int FL_OVFM_BIT = 6;
	localparam int FL_S_CH1 = 5;
	localparam int FL_S_CH0 = 4;
	localparam int FL_S_OVF = 3;
	localparam int FL_F_CH1 = 2;
	localparam int FL_F_CH0 = 1;
	localparam int FL_F_OVF = 0;
	localparam logic [7:0] FLAGS_RST  = 8'h40;
	localparam logic [7:0] FLAGS_PEND = 8'h3F;
	// Interrupt status bits
	localparam int ST_MATCH = 0;
	localparam int ST_FLAG  = 1;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ACT_SET   = 3'h0,
		ACT_CLR   = 3'h1,
		ACT_TGL   = 3'h2,
		ACT_SETUP = 3'h3,
		ACT_CLRUP = 3'h4,
		ACT_SETC0 = 3'h5,
		ACT_CLRC0 = 3'h6,
		ACT_NONE  = 3'h7
	} tcc_act_t;
endpackage

// >>> tcc_cmp_if.sv
// Link between register logic and the compare action unit
`timescale 1ns/1ps
interface tcc_cmp_if;
	logic [7:0]        count;
	logic [7:0]        ch0;
	logic [7:0]        ch1;
	tcc_pkg::tcc_act_t action;
	logic              enable;
	logic              tick;
	logic              down;
	logic              updown;
	logic              pin;
	logic              match;
	modport ctl (output count, ch0, ch1, action, enable, tick, down, updown, input pin, match);
	modport unit (input count, ch0, ch1, action, enable, tick, down, updown, output pin, match);
endinterface

// >>> tcc_cmp_unit.sv
// Compare action unit driving the channel 1 output
`timescale 1ns/1ps
module tcc_cmp_unit (
	input  wire logic aclk,
	input  wire logic aresetn,
	tcc_cmp_if.unit   cmp
);
	logic pin_reg;
	logic pin_next;
	logic at_zero;
	logic at_ch0;
	logic down_cmp;

	assign cmp.pin = pin_reg;
	assign cmp.match = cmp.enable && cmp.tick && (cmp.count == cmp.ch1);
	assign at_zero = cmp.enable && cmp.tick && (cmp.count == 8'h00);
	assign at_ch0 = cmp.enable && cmp.tick && (cmp.count == cmp.ch0);
	// down compares only arise in up/down
	assign down_cmp = cmp.updown && cmp.down;

	always_comb begin
		pin_next = pin_reg;
		case (cmp.action)
			tcc_pkg::ACT_SET: if (cmp.match) pin_next = 1'b1;
			tcc_pkg::ACT_CLR: if (cmp.match) pin_next = 1'b0;
			tcc_pkg::ACT_TGL: if (cmp.match) pin_next = !pin_reg;
			tcc_pkg::ACT_SETUP: begin
				if (cmp.match)
					pin_next = !down_cmp;
				else if (at_zero)
					pin_next = 1'b0;
			end
			tcc_pkg::ACT_CLRUP: begin
				if (cmp.match)
					pin_next = down_cmp;
				else if (at_zero)
					pin_next = 1'b1;
			end
			tcc_pkg::ACT_SETC0: begin
				if (cmp.match)
					pin_next = 1'b1;
				else if (at_ch0)
					pin_next = 1'b0;
			end
			tcc_pkg::ACT_CLRC0: begin
				if (cmp.match)
					pin_next = 1'b0;
				else if (at_ch0)
					pin_next = 1'b1;
			end
			default: pin_next = pin_reg;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			pin_reg <= 1'b0;
		else
			pin_reg <= pin_next;
	end

	a_set_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp.match && cmp.action == tcc_pkg::ACT_SET |=> pin_reg)
		else $error("set action did not drive output high");
	a_tgl_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp.match && cmp.action == tcc_pkg::ACT_TGL |=> pin_reg != $past(pin_reg))
		else $error("toggle action did not invert output");
	a_updown_down_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		cmp.match && cmp.action == tcc_pkg::ACT_SETUP && cmp.updown && cmp.down |=> !pin_reg)
		else $error("compare-down did not clear output");
	a_zero_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		at_zero && !cmp.match && cmp.action == tcc_pkg::ACT_SETUP |=> !pin_reg)
		else $error("count zero did not clear output");
	a_ch0_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		at_ch0 && !cmp.match && cmp.action == tcc_pkg::ACT_SETC0 |=> !pin_reg)
		else $error("channel 0 value did not clear output");
	c_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
		cmp.match && cmp.action == tcc_pkg::ACT_TGL);
	c_updown: cover property (@(posedge aclk) disable iff (!aresetn)
		cmp.match && down_cmp && cmp.action == tcc_pkg::ACT_CLRUP);
endmodule

// >>> tb.sv
// Self-checking bench for the timer channel 1 compare block
`timescale 1ns/1ps
module tb;
	logic        aclk;
	logic        aresetn;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic [31:0] wdata;
	logic        awvalid;
	logic        wvalid;
	logic        arvalid;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic [7:0]  cnt;
	logic [7:0]  ch0b;
	logic        tick;
	logic        cdn;
	logic        updn;
	logic        wpend;
	logic [4:0]  evt;
	logic        ch1_out;
	logic        ch1_irq;
	logic        wide_irq;
	logic        irq;
	logic [31:0] rd_val;
	logic [7:0]  exp_fl;
	int          err_count;
	int          checked;
	int          fpos[5] = '{1, 2, 0, 4, 3};

	tcc_top #(.ADDR_W(tcc_pkg::ADDR_W)) u_dut (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (awaddr),
		.s_axi_awprot         (3'h0),
		.s_axi_awvalid        (awvalid),
		.s_axi_awready        (awready),
		.s_axi_wdata          (wdata),
		.s_axi_wstrb          (4'hF),
		.s_axi_wvalid         (wvalid),
		.s_axi_wready         (wready),
		.s_axi_bresp          (bresp),
		.s_axi_bvalid         (bvalid),
		.s_axi_bready         (1'b1),
		.s_axi_araddr         (araddr),
		.s_axi_arprot         (3'h0),
		.s_axi_arvalid        (arvalid),
		.s_axi_arready        (arready),
		.s_axi_rdata          (rdata),
		.s_axi_rresp          (rresp),
		.s_axi_rvalid         (rvalid),
		.s_axi_rready         (1'b1),
		.timer_count          (cnt),
		.timer_tick           (tick),
		.ch0_compare_byte     (ch0b),
		.count_down           (cdn),
		.updown_mode          (updn),
		.first_timer_ch0_evt  (evt[0]),
		.first_timer_ch1_evt  (evt[1]),
		.first_timer_ovf_evt  (evt[2]),
		.second_timer_ch0_evt (evt[3]),
		.second_timer_ovf_evt (evt[4]),
		.wide_ovf_pending     (wpend),
		.ch1_out              (ch1_out),
		.ch1_irq_req          (ch1_irq),
		.wide_ovf_irq_req     (wide_irq),
		.irq                  (irq)
	);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bready is tied high, so the response is taken at the edge it is seen
	// Only the watchdog ends a wait that never gets its answer
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v, tcc_pkg::RESP_OKAY);
		chk(nm, e, v);
	endtask

	// Enabled, channel interrupt unmasked, given action
	task setact(input logic [2:0] a);
		wr(tcc_pkg::ADDR_CTRL, {2'b01, a, 3'b100}, tcc_pkg::RESP_OKAY);
	endtask

	// Output is sampled just after the edge that takes the tick
	task tk(input logic [7:0] c, input logic d, input logic e);
		@(posedge aclk);
		cnt <= c;
		cdn <= d;
		tick <= 1'b1;
		@(posedge aclk);
		tick <= 1'b0;
		#1;
		chk("ch1_out", {31'h0, e}, {31'h0, ch1_out});
	endtask

	task pulse(input int i);
		@(posedge aclk);
		evt <= 5'h01 << i;
		@(posedge aclk);
		evt <= 5'h00;
	endtask

	task conclude;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Whole run needs well under two thousand cycles
	initial begin
		#(100 * 20000);
		err_count++;
		conclude;
	end

	initial begin
		err_count = 0;
		checked = 0;
		aresetn = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		cnt = 8'h00;
		ch0b = 8'h30;
		tick = 1'b0;
		cdn = 1'b0;
		updn = 1'b0;
		wpend = 1'b0;
		evt = 5'h00;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h40);
		rdc("ctrl", tcc_pkg::ADDR_CTRL, 32'h40);
		rdc("value", tcc_pkg::ADDR_VALUE, 32'h00);
		chk("ch1_out", 32'h0, {31'h0, ch1_out});
		wr(tcc_pkg::ADDR_VALUE, 8'hA5, tcc_pkg::RESP_OKAY);
		rdc("value", tcc_pkg::ADDR_VALUE, 32'hA5);
		wr(tcc_pkg::ADDR_CTRL, 8'hFF, tcc_pkg::RESP_OKAY);
		rdc("ctrl", tcc_pkg::ADDR_CTRL, 32'h7F);
		wr(12'h010, 8'h55, tcc_pkg::RESP_SLVERR);
		rd(12'h010, rd_val, tcc_pkg::RESP_SLVERR);
		chk("unmapped", 32'h0, rd_val);
		wr(tcc_pkg::ADDR_VALUE, 8'h20, tcc_pkg::RESP_OKAY);
		setact(3'h0);
		tk(8'h20, 1'b0, 1'b1);
		setact(3'h1);
		tk(8'h21, 1'b0, 1'b1);
		tk(8'h20, 1'b0, 1'b0);
		setact(3'h2);
		tk(8'h20, 1'b0, 1'b1);
		tk(8'h20, 1'b0, 1'b0);
		setact(3'h3);
		tk(8'h20, 1'b0, 1'b1);
		tk(8'h00, 1'b0, 1'b0);
		updn <= 1'b1;
		tk(8'h20, 1'b0, 1'b1);
		tk(8'h20, 1'b1, 1'b0);
		setact(3'h4);
		tk(8'h20, 1'b0, 1'b0);
		tk(8'h20, 1'b1, 1'b1);
		updn <= 1'b0;
		tk(8'h20, 1'b0, 1'b0);
		tk(8'h00, 1'b0, 1'b1);
		setact(3'h5);
		tk(8'h30, 1'b0, 1'b0);
		tk(8'h20, 1'b0, 1'b1);
		tk(8'h30, 1'b0, 1'b0);
		setact(3'h6);
		tk(8'h20, 1'b0, 1'b0);
		tk(8'h30, 1'b0, 1'b1);
		setact(3'h7);
		tk(8'h20, 1'b0, 1'b1);
		// Disabled with action clear: a match must not reach the pin
		wr(tcc_pkg::ADDR_CTRL, 8'h48, tcc_pkg::RESP_OKAY);
		tk(8'h20, 1'b0, 1'b1);
		chk("ch1_irq", 32'h1, {31'h0, ch1_irq});
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h60);
		wr(tcc_pkg::ADDR_CTRL, 8'h08, tcc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		#1;
		chk("ch1_irq", 32'h0, {31'h0, ch1_irq});
		exp_fl = 8'h60;
		for (int i = 0; i < 5; i++) begin
			pulse(i);
			exp_fl[fpos[i]] = 1'b1;
			rdc("flags", tcc_pkg::ADDR_FLAGS, {24'h0, exp_fl});
		end
		wr(tcc_pkg::ADDR_FLAGS, 8'hFF, tcc_pkg::RESP_OKAY);
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h7F);
		wr(tcc_pkg::ADDR_FLAGS, 8'h40, tcc_pkg::RESP_OKAY);
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h40);
		// Two first timer events in one cycle both land
		@(posedge aclk);
		evt <= 5'h05;
		@(posedge aclk);
		evt <= 5'h00;
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h43);
		wpend <= 1'b1;
		repeat (2) @(posedge aclk);
		#1;
		chk("wide_irq", 32'h1, {31'h0, wide_irq});
		wr(tcc_pkg::ADDR_FLAGS, 8'h00, tcc_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		#1;
		chk("wide_irq", 32'h0, {31'h0, wide_irq});
		rdc("flags", tcc_pkg::ADDR_FLAGS, 32'h00);
		// Interrupt: clear status, unmask the match bit, then match
		rdc("stat", tcc_pkg::ADDR_STAT, 32'h3);
		rdc("stat", tcc_pkg::ADDR_STAT, 32'h0);
		wr(tcc_pkg::ADDR_MASK, 8'h01, tcc_pkg::RESP_OKAY);
		rdc("mask", tcc_pkg::ADDR_MASK, 32'h01);
		setact(3'h1);
		tk(8'h20, 1'b0, 1'b0);
		@(posedge aclk);
		#1;
		chk("irq", 32'h1, {31'h0, irq});
		chk("ch1_irq", 32'h1, {31'h0, ch1_irq});
		rd(tcc_pkg::ADDR_STAT, rd_val, tcc_pkg::RESP_OKAY);
		chk("stat_match", 32'h1, rd_val & 32'h1);
		repeat (2) @(posedge aclk);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		wr(tcc_pkg::ADDR_MASK, 8'h00, tcc_pkg::RESP_OKAY);
		tk(8'h20, 1'b0, 1'b0);
		repeat (2) @(posedge aclk);
		#1;
		chk("irq", 32'h0, {31'h0, irq});
		rd(tcc_pkg::ADDR_STAT, rd_val, tcc_pkg::RESP_OKAY);
		chk("stat_match", 32'h1, rd_val & 32'h1);
		conclude;
	end
endmodule
